// file: core/dmd_params.svh
// constants for the banked data memory decoder: offsets, reset values
// assumes inclusion by bare name from the design file only
`ifndef DMD_PARAMS_SVH
`define DMD_PARAMS_SVH

// core register offsets inside every bank
`define DMD_OFS_INDIRECT_PORT_0 7'h00
`define DMD_OFS_INDIRECT_PORT_1 7'h01
`define DMD_OFS_PC_LOW 7'h02
`define DMD_OFS_CORE_STATUS 7'h03
`define DMD_OFS_POINTER0_LOW 7'h04
`define DMD_OFS_POINTER0_HIGH 7'h05
`define DMD_OFS_POINTER1_LOW 7'h06
`define DMD_OFS_POINTER1_HIGH 7'h07
`define DMD_OFS_BANK_SELECT 7'h08
`define DMD_OFS_WORKING_REG 7'h09
`define DMD_OFS_PC_HIGH_LATCH 7'h0A
`define DMD_OFS_INT_CONTROL 7'h0B

// in-bank region boundaries
`define DMD_CORE_END 7'h0C
`define DMD_GENERAL_START 7'h20
`define DMD_COMMON_START 7'h70
`define DMD_GENERAL_BYTES 13'h0050
`define DMD_COMMON_BYTES 16
`define DMD_BANK_COUNT 64
`define DMD_GENERAL_BANKS 60

// pointer window tags for the linear view of general ram and the banked view
`define DMD_LINEAR_TAG 3'h1
`define DMD_BANKED_TAG 3'h0

// reset value of core registers and the bank select write mask
`define DMD_RESET_BYTE 8'h00
`define DMD_BANK_MASK 8'h3F

`endif

// file: core/dmd_pkg.sv
// types shared by the banked data memory decoder
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package dmd_pkg;

  // one-hot decode result of a 13-bit data address
  typedef enum logic [4:0] {
    REGION_NONE    = 5'h01,
    REGION_CORE    = 5'h02,
    REGION_PERIPH  = 5'h04,
    REGION_GENERAL = 5'h08,
    REGION_COMMON  = 5'h10
  } dmd_region_e;

  typedef logic [12:0] dmd_addr_t;

endpackage : dmd_pkg
`default_nettype wire

// file: core/dmd_decoder.sv
// banked data memory decoder: core registers, general ram, common ram,
// and a strobe port out to the peripheral registers.
// assumes the core issues one access at a time, same clock, and that
// peripheral read data is valid in the cycle its strobe is high.
//
// Summary of operation
// [RULE1] up to 64 banks of 128 bytes each
// [RULE2] direct accesses use the bank last written to bank select
// [RULE3] any location reachable directly or through either pointer pair
// [RULE4] data addresses are 13 bits
// [RULE5] upper six bits pick the bank, lower seven the offset
// [RULE6] first 12 offsets of every bank reach the same core registers
// [RULE7] core registers sit in fixed order at offsets 00h to 0Bh
// [RULE8] banks 0 to 59 hold 20 peripheral bytes after core registers
// [RULE9] banks 60 to 63 hold 100 peripheral bytes after core registers
// [RULE10] each bank offers up to 80 bytes of general ram
// [RULE11] general ram is also one linear space through the pointers
// [RULE12] 16 bytes of common ram are shared by all banks
// [RULE13] common ram at 70h-7Fh, general ram at 20h-6Fh
// [RULE14] unimplemented locations read zero and ignore writes
`timescale 1ns/10ps
`default_nettype none
`include "dmd_params.svh"

module dmd_decoder #(
  parameter int NUM_BANKS = `DMD_BANK_COUNT,
  parameter int GP_BANKS = `DMD_GENERAL_BANKS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire logic acc_write,
  input wire logic [6:0] acc_offset,
  input wire logic [7:0] acc_wdata,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic per_sel,
  output logic per_write,
  output logic [12:0] per_addr,
  output logic [7:0] per_wdata,
  input wire logic [7:0] per_rdata,
  output logic [7:0] bank_select,
  output logic [15:0] pointer0,
  output logic [15:0] pointer1,
  output logic [7:0] working_register,
  output logic [7:0] program_counter_low,
  output logic [7:0] program_counter_high_latch,
  output logic [7:0] core_status,
  output logic [7:0] interrupt_control
);

  localparam int GP_DEPTH = GP_BANKS * 80;

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] gp_mem [0:GP_DEPTH-1];
  logic [7:0] common_mem [0:`DMD_COMMON_BYTES-1];

  logic [7:0] bank_select_reg;
  logic [7:0] pointer0_low_reg;
  logic [7:0] pointer0_high_reg;
  logic [7:0] pointer1_low_reg;
  logic [7:0] pointer1_high_reg;
  logic [7:0] working_reg;
  logic [7:0] pc_low_reg;
  logic [7:0] pc_high_latch_reg;
  logic [7:0] core_status_reg;
  logic [7:0] int_control_reg;

  logic st_valid_reg;
  logic st_write_reg;
  logic [7:0] st_wdata_reg;
  dmd_pkg::dmd_region_e st_region_reg;
  logic [12:0] st_index_reg;
  dmd_pkg::dmd_addr_t st_addr_reg;
  logic rd_valid_reg;
  logic [7:0] rd_data_reg;
  logic acc_ready_reg;
  logic per_sel_reg;

  ////////////////////////////////////////////////////////////////////////
  // address formation and decode

  logic [15:0] sel_ptr;
  logic use_ptr;
  logic linear;
  logic in_range;
  dmd_pkg::dmd_addr_t eff_addr;
  logic [5:0] eff_bank;
  logic [6:0] eff_ofs;
  dmd_pkg::dmd_region_e region_next;
  logic [12:0] index_next;

  always_comb begin
    use_ptr = (acc_offset == `DMD_OFS_INDIRECT_PORT_0) ||
              (acc_offset == `DMD_OFS_INDIRECT_PORT_1); // see [RULE3]
    sel_ptr = (acc_offset == `DMD_OFS_INDIRECT_PORT_1) ?
              {pointer1_high_reg, pointer1_low_reg} :
              {pointer0_high_reg, pointer0_low_reg};
    linear = 1'b0;
    in_range = 1'b1;
    if (!use_ptr) begin
      eff_addr = {bank_select_reg[5:0], acc_offset}; // see [RULE2] [RULE4]
    end else if (sel_ptr[15:13] == `DMD_LINEAR_TAG) begin
      eff_addr = sel_ptr[12:0];
      linear = 1'b1;
    end else if (sel_ptr[15:13] == `DMD_BANKED_TAG) begin
      eff_addr = sel_ptr[12:0];
    end else begin
      eff_addr = 13'h0000;
      in_range = 1'b0;
    end
    eff_bank = eff_addr[12:7]; // see [RULE5]
    eff_ofs = eff_addr[6:0];
    region_next = dmd_pkg::REGION_NONE;
    index_next = 13'h0000;
    if (!in_range) begin
      region_next = dmd_pkg::REGION_NONE; // see [RULE14]
    end else if (linear) begin
      // linear view indexes the general ram store directly
      if (eff_addr < 13'(GP_DEPTH)) begin // see [RULE11]
        region_next = dmd_pkg::REGION_GENERAL;
        index_next = eff_addr;
      end
    end else if (32'(eff_bank) >= NUM_BANKS) begin
      region_next = dmd_pkg::REGION_NONE; // see [RULE1] [RULE14]
    end else if (eff_ofs < `DMD_CORE_END) begin
      // an indirect port reached through a pointer is unimplemented
      if (!(use_ptr && eff_ofs <= `DMD_OFS_INDIRECT_PORT_1)) begin
        region_next = dmd_pkg::REGION_CORE; // see [RULE6]
        index_next = {6'h00, eff_ofs};
      end
    end else if (eff_ofs >= `DMD_COMMON_START) begin
      region_next = dmd_pkg::REGION_COMMON; // see [RULE12] [RULE13]
      index_next = {9'h000, eff_ofs[3:0]};
    end else if (eff_ofs < `DMD_GENERAL_START) begin
      region_next = dmd_pkg::REGION_PERIPH; // see [RULE8]
    end else if (32'(eff_bank) >= GP_BANKS) begin
      region_next = dmd_pkg::REGION_PERIPH; // see [RULE9]
    end else begin
      region_next = dmd_pkg::REGION_GENERAL; // see [RULE10] [RULE13]
      index_next = 13'({7'h00, eff_bank} * `DMD_GENERAL_BYTES) +
                   13'({6'h00, eff_ofs} - {6'h00, `DMD_GENERAL_START});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request stage: one access in flight keeps pointer and bank updates
  // ordered, at the price of one access every two cycles

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_valid_reg <= 1'b0;
      st_write_reg <= 1'b0;
      st_wdata_reg <= 8'h00;
      st_region_reg <= dmd_pkg::REGION_NONE;
      st_index_reg <= 13'h0000;
      st_addr_reg <= 13'h0000;
      acc_ready_reg <= 1'b1;
      per_sel_reg <= 1'b0;
    end else begin
      st_valid_reg <= acc_valid && !st_valid_reg;
      acc_ready_reg <= !(acc_valid && !st_valid_reg);
      per_sel_reg <= acc_valid && !st_valid_reg &&
                     (region_next == dmd_pkg::REGION_PERIPH); // see [RULE8]
      if (acc_valid && !st_valid_reg) begin
        st_write_reg <= acc_write;
        st_wdata_reg <= acc_wdata;
        st_region_reg <= region_next;
        st_index_reg <= index_next;
        st_addr_reg <= eff_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execute stage: storage writes

  logic do_write;
  assign do_write = st_valid_reg && st_write_reg;

  always_ff @(posedge core_clk) begin
    if (do_write && st_region_reg == dmd_pkg::REGION_GENERAL) begin
      gp_mem[st_index_reg] <= st_wdata_reg; // see [RULE10] [RULE11]
    end
    if (do_write && st_region_reg == dmd_pkg::REGION_COMMON) begin
      common_mem[st_index_reg[3:0]] <= st_wdata_reg; // see [RULE12]
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_select_reg <= `DMD_RESET_BYTE;
      pointer0_low_reg <= `DMD_RESET_BYTE;
      pointer0_high_reg <= `DMD_RESET_BYTE;
      pointer1_low_reg <= `DMD_RESET_BYTE;
      pointer1_high_reg <= `DMD_RESET_BYTE;
      working_reg <= `DMD_RESET_BYTE;
      pc_low_reg <= `DMD_RESET_BYTE;
      pc_high_latch_reg <= `DMD_RESET_BYTE;
      core_status_reg <= `DMD_RESET_BYTE;
      int_control_reg <= `DMD_RESET_BYTE;
    end else if (do_write && st_region_reg == dmd_pkg::REGION_CORE) begin
      case (st_index_reg[6:0]) // see [RULE7]
        `DMD_OFS_PC_LOW: begin
          pc_low_reg <= st_wdata_reg;
        end
        `DMD_OFS_CORE_STATUS: begin
          core_status_reg <= st_wdata_reg;
        end
        `DMD_OFS_POINTER0_LOW: begin
          pointer0_low_reg <= st_wdata_reg;
        end
        `DMD_OFS_POINTER0_HIGH: begin
          pointer0_high_reg <= st_wdata_reg;
        end
        `DMD_OFS_POINTER1_LOW: begin
          pointer1_low_reg <= st_wdata_reg;
        end
        `DMD_OFS_POINTER1_HIGH: begin
          pointer1_high_reg <= st_wdata_reg;
        end
        `DMD_OFS_BANK_SELECT: begin
          // only six bank bits exist; the rest read zero
          bank_select_reg <= st_wdata_reg & `DMD_BANK_MASK; // see [RULE2]
        end
        `DMD_OFS_WORKING_REG: begin
          working_reg <= st_wdata_reg;
        end
        `DMD_OFS_PC_HIGH_LATCH: begin
          pc_high_latch_reg <= st_wdata_reg;
        end
        `DMD_OFS_INT_CONTROL: begin
          int_control_reg <= st_wdata_reg;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execute stage: read answer

  logic [7:0] core_rdata;

  always_comb begin
    case (st_index_reg[6:0]) // see [RULE7]
      `DMD_OFS_PC_LOW: core_rdata = pc_low_reg;
      `DMD_OFS_CORE_STATUS: core_rdata = core_status_reg;
      `DMD_OFS_POINTER0_LOW: core_rdata = pointer0_low_reg;
      `DMD_OFS_POINTER0_HIGH: core_rdata = pointer0_high_reg;
      `DMD_OFS_POINTER1_LOW: core_rdata = pointer1_low_reg;
      `DMD_OFS_POINTER1_HIGH: core_rdata = pointer1_high_reg;
      `DMD_OFS_BANK_SELECT: core_rdata = bank_select_reg;
      `DMD_OFS_WORKING_REG: core_rdata = working_reg;
      `DMD_OFS_PC_HIGH_LATCH: core_rdata = pc_high_latch_reg;
      `DMD_OFS_INT_CONTROL: core_rdata = int_control_reg;
      default: core_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      rd_valid_reg <= st_valid_reg && !st_write_reg;
      if (st_valid_reg && !st_write_reg) begin
        case (st_region_reg)
          dmd_pkg::REGION_CORE: rd_data_reg <= core_rdata;
          dmd_pkg::REGION_PERIPH: rd_data_reg <= per_rdata;
          dmd_pkg::REGION_GENERAL: rd_data_reg <= gp_mem[st_index_reg];
          dmd_pkg::REGION_COMMON: begin
            rd_data_reg <= common_mem[st_index_reg[3:0]];
          end
          default: rd_data_reg <= 8'h00; // see [RULE14]
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign acc_ready = acc_ready_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;
  // strobe is its own flop so the peripheral never sees decode glitches
  assign per_sel = per_sel_reg; // see [RULE8]
  assign per_write = st_write_reg;
  assign per_addr = st_addr_reg;
  assign per_wdata = st_wdata_reg;
  assign bank_select = bank_select_reg;
  assign pointer0 = {pointer0_high_reg, pointer0_low_reg};
  assign pointer1 = {pointer1_high_reg, pointer1_low_reg};
  assign working_register = working_reg;
  assign program_counter_low = pc_low_reg;
  assign program_counter_high_latch = pc_high_latch_reg;
  assign core_status = core_status_reg;
  assign interrupt_control = int_control_reg;

endmodule : dmd_decoder

`default_nettype wire

// file: verification/dmd_props.sv
// checker on the decoder access and strobe ports
// assumes binding onto dmd_decoder, one clock domain
`timescale 1ns/10ps
`default_nettype none
module dmd_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic acc_valid,
  input wire logic acc_ready,
  input wire logic acc_write,
  input wire logic [6:0] acc_offset,
  input wire logic [7:0] acc_wdata,
  input wire logic rd_valid,
  input wire logic per_sel,
  input wire logic [12:0] per_addr,
  input wire logic [7:0] bank_select
);
  wire logic tk;
  wire logic hi;
  assign tk = acc_valid && acc_ready;
  assign hi = bank_select >= 8'h3C;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  property p_take; tk |=> !acc_ready; endproperty
  a_take: assert property (p_take)
    else $error("ready stayed high");
  property p_rd; tk && !acc_write |-> ##2 rd_valid; endproperty
  a_rd: assert property (p_rd)
    else $error("read answer missing");
  property p_bsm; bank_select[7:6] == 2'b00; endproperty
  a_bsm: assert property (p_bsm)
    else $error("bank select upper bits set");
  property p_bsw;
    tk && acc_write && acc_offset == 7'h08
      |-> ##2 bank_select == (8'h3F & $past(acc_wdata, 2));
  endproperty
  a_bsw: assert property (p_bsw)
    else $error("bank select not written");
  property p_core; tk && acc_offset inside {[7'h02:7'h0B]} |=> !per_sel;
  endproperty
  a_core: assert property (p_core)
    else $error("core offset reached peripheral");
  property p_per;
    tk && acc_offset inside {[7'h0C:7'h1F]} |=> per_sel
      && per_addr[6:0] == $past(acc_offset)
      && {2'b00, per_addr[12:7]} == $past(bank_select);
  endproperty
  a_per: assert property (p_per)
    else $error("peripheral strobe or address wrong");
  property p_hi; tk && hi && acc_offset inside {[7'h20:7'h6F]} |=> per_sel;
  endproperty
  a_hi: assert property (p_hi)
    else $error("upper bank peripheral missed");
  property p_lo; tk && !hi && acc_offset inside {[7'h20:7'h6F]} |=> !per_sel;
  endproperty
  a_lo: assert property (p_lo)
    else $error("general ram reached peripheral");
  property p_com; tk && acc_offset >= 7'h70 |=> !per_sel; endproperty
  a_com: assert property (p_com)
    else $error("common ram reached peripheral");
  c_rd: cover property (tk && !acc_write);
  c_per: cover property (per_sel);
  c_hi: cover property (tk && hi);
endmodule : dmd_props
bind dmd_decoder dmd_props dmd_props_i (.core_clk, .rst_b, .acc_valid,
  .acc_ready, .acc_write, .acc_offset, .acc_wdata, .rd_valid, .per_sel,
  .per_addr, .bank_select);
`default_nettype wire

// file: verification/dmd_periph_model.sv
// peripheral register stand-in on the decoder strobe port
// assumes read data is wanted in the strobe cycle, same clock
`timescale 1ns/10ps
`default_nettype none
module dmd_periph_model (
  input wire logic core_clk,
  input wire logic per_sel,
  input wire logic per_write,
  input wire logic [12:0] per_addr,
  input wire logic [7:0] per_wdata,
  output logic [7:0] per_rdata
);
  logic [7:0] mem [0:8191];
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // off-strobe data is inverted so a late sample cannot pass
  assign per_rdata = per_sel ? mem[per_addr] : ~last;
  always @(posedge core_clk) begin
    if (per_sel) begin
      last <= mem[per_addr];
      if (per_write) begin
        mem[per_addr] <= per_wdata;
      end
    end
  end
endmodule : dmd_periph_model
`default_nettype wire

// file: verification/dmd_decoder_tb_top.sv
// self-checking bench for the data memory decoder
// assumes the peripheral stand-in and checker compile first
`timescale 1ns/10ps
`default_nettype none
module dmd_decoder_tb_top;
  logic core_clk = 1'b0;
  logic rst_b, acc_valid, acc_write, acc_ready, rd_valid, per_sel, per_write;
  logic [6:0] acc_offset;
  logic [7:0] acc_wdata, rd_data, per_wdata, per_rdata, bank_select, v;
  logic [7:0] working_register, program_counter_low, core_status;
  logic [7:0] program_counter_high_latch, interrupt_control;
  logic [12:0] per_addr;
  logic [15:0] pointer0, pointer1;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  dmd_decoder dmd_decoder_i (.core_clk, .rst_b, .acc_valid, .acc_ready,
    .acc_write, .acc_offset, .acc_wdata, .rd_valid, .rd_data, .per_sel,
    .per_write, .per_addr, .per_wdata, .per_rdata, .bank_select, .pointer0,
    .pointer1, .working_register, .program_counter_low,
    .program_counter_high_latch, .core_status, .interrupt_control);
  dmd_periph_model dmd_periph_model_i (.core_clk, .per_sel, .per_write,
    .per_addr, .per_wdata, .per_rdata);
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task final_report;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // one access; answer missing leaves q unknown so the compare fails
  task rw(input logic w, input logic [6:0] o, input logic [7:0] d,
          output logic [7:0] q);
    q = 8'hXX;
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_offset <= o;
    acc_wdata <= d;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    repeat (3) begin
      @(negedge core_clk);
      if (rd_valid === 1'b1) q = rd_data;
    end
  endtask : rw
  function automatic logic [7:0] pat(input logic [5:0] b, input logic [6:0] o);
    return {b[0], o} ^ 8'h5A;
  endfunction : pat
  task set_bank(input logic [7:0] b);
    rw(1'b1, 7'h08, b, v);
  endtask : set_bank
  task setp(input logic n, input logic [15:0] p);
    rw(1'b1, n ? 7'h06 : 7'h04, p[7:0], v);
    rw(1'b1, n ? 7'h07 : 7'h05, p[15:8], v);
  endtask : setp
  ////////////////////////////////////////
  task t_core;
    set_bank(8'hFF);
    chk(bank_select, 8'h3F, "bank_select");
    for (int i = 2; i < 12; i++) begin
      if (i != 8) rw(1'b1, 7'(i), 8'(i) + 8'h40, v);
    end
    for (int b = 0; b < 2; b++) begin
      set_bank(8'(b * 5));
      for (int i = 2; i < 12; i++) begin
        rw(1'b0, 7'(i), 8'h00, v);
        chk(v, i==8 ? 8'(b*5) : 8'(i) + 8'h40, "core");
      end
    end
    chk(pointer0, 16'h4544, "pointer0");
    chk({core_status, interrupt_control}, 16'h434B, "status");
    chk(pointer1, 16'h4746, "pointer1");
    chk(program_counter_low, 8'h42, "pcl");
    chk(program_counter_high_latch, 8'h4A, "pch");
    chk(working_register, 8'h49, "working_register");
  endtask : t_core
  task t_per;
    logic [5:0] bk [4] = '{6'h00, 6'h3B, 6'h3C, 6'h3F};
    logic [6:0] of [4] = '{7'h0C, 7'h1F, 7'h20, 7'h6F};
    for (int i = 0; i < 4; i++) begin
      set_bank({2'b00, bk[i]});
      rw(1'b0, of[i], 8'h00, v);
      chk(v, pat(bk[i], of[i]), "periph");
    end
    rw(1'b1, 7'h30, 8'hA5, v);
    rw(1'b0, 7'h30, 8'h00, v);
    chk(v, 8'hA5, "periph write");
  endtask : t_per
  task t_ram;
    set_bank(8'h03);
    rw(1'b1, 7'h20, 8'h11, v);
    rw(1'b1, 7'h6F, 8'h22, v);
    rw(1'b1, 7'h75, 8'h33, v);
    set_bank(8'h28);
    rw(1'b0, 7'h75, 8'h00, v);
    chk(v, 8'h33, "common");
    setp(1'b0, 16'h01A0);
    rw(1'b0, 7'h00, 8'h00, v);
    chk(v, 8'h11, "ptr0");
    setp(1'b1, 16'h213F);
    rw(1'b0, 7'h01, 8'h00, v);
    chk(v, 8'h22, "ptr1 linear");
    setp(1'b1, 16'h2000);
    rw(1'b1, 7'h01, 8'h44, v);
    set_bank(8'h00);
    rw(1'b0, 7'h20, 8'h00, v);
    chk(v, 8'h44, "linear");
    setp(1'b0, 16'h4000);
    setp(1'b1, 16'h32C0);
    for (int i = 0; i < 2; i++) begin
      rw(1'b1, 7'(i), 8'h77, v);
      rw(1'b0, 7'(i), 8'h00, v);
      chk(v, 8'h00, "unimpl");
    end
  endtask : t_ram
  // mid-run reset: registers must fall back and the port must reopen
  task t_rst;
    set_bank(8'h2A);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk({bank_select, 7'h00, acc_ready}, 16'h0001, "rst bank");
    chk(pointer0 | pointer1, 16'h0000, "rst ptr");
    chk({working_register, core_status}, 16'h0000, "rst core");
  endtask : t_rst
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_offset = 7'h00;
    acc_wdata = 8'h00;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    t_core();
    t_per();
    t_ram();
    t_rst();
    t_per();
    final_report();
  end
endmodule : dmd_decoder_tb_top
`default_nettype wire
